// [hw/sdl_defs.svh]
/*
 * Constants of the serial converter load port: word width, codes, reset.
 * Assumes inclusion by the package, the top module and the test bench.
 */
`ifndef SDL_DEFS_SVH
`define SDL_DEFS_SVH

// ************************************************************
// Word layout
// ************************************************************
`define SDL_CODE_W 14
`define SDL_CODE_MSB 13
`define SDL_CODE_LSB 0

// ************************************************************
// Codes and reset
// ************************************************************
`define SDL_CODE_RESET 14'h0000
`define SDL_CODE_FULL 14'h3FFF
`define SDL_CODE_ZERO 14'h0000

// ************************************************************
// Frame counting
// ************************************************************
`define SDL_HOST_WORD_BITS 5'h10
`define SDL_RISE_CNT_MAX 5'h1F

`endif

// [hw/sdl_pkg.sv]
/*
 * Types of the serial converter load port.
 * Assumes sdl_defs.svh is on the include path.
 */
`include "sdl_defs.svh"

package sdl_pkg;
   typedef logic [`SDL_CODE_W-1:0] sdl_code_t;

   // Synchronised view of the three host wires
   typedef struct packed {
      logic clk_lvl;
      logic data_lvl;
      logic sel_n_lvl;
   } sdl_wires_t;
endpackage

// [hw/sdl_load_port.sv]
/*
 * Serial load port: three host wires fill a shift register; the rising
 * edge of the active-low select copies the last 14 bits to the code
 * register that drives the ladder switches.
 * Assumes host wires are asynchronous to I_CLOCK and slow enough that
 * each level lasts at least three I_CLOCK periods.
 * Assumes I_NRST stands in for power-up, clearing shifter and code.
 * Assumes the surrounding logic may ignore the scale and load flags.
 */
`timescale 1ns/1ps
`include "sdl_defs.svh"

module sdl_load_port
   import sdl_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_NRST,
   input wire logic I_SERIAL_CLK,
   input wire logic I_SERIAL_DATA_IN,
   input wire logic I_SELECT_N,
   output logic [`SDL_CODE_W-1:0] O_LEG_TO_CURRENT_OUTPUT,
   output logic O_FULL_SCALE,
   output logic O_ZERO_SCALE,
   output logic O_CODE_LOADED
);

   // ************************************************************
   // Synchronisers
   // ************************************************************
   // Two flops before any logic; prev only keeps the old level so that
   // edges of the slow host wires can be found on I_CLOCK
   sdl_wires_t meta_reg;
   sdl_wires_t sync_reg;
   sdl_wires_t prev_reg;
   sdl_wires_t meta_next;
   sdl_wires_t sync_next;
   sdl_wires_t prev_next;

   always_comb begin
      meta_next = '{clk_lvl: I_SERIAL_CLK, data_lvl: I_SERIAL_DATA_IN,
                    sel_n_lvl: I_SELECT_N};
      sync_next = meta_reg;
      prev_next = sync_reg;
   end

   // Select resets high so no load fires just after reset
   always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
         meta_reg <= 3'h1;
         sync_reg <= 3'h1;
         prev_reg <= 3'h1;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         prev_reg <= prev_next;
      end
   end

   logic clk_rise;
   logic sel_rise;
   assign clk_rise = sync_reg.clk_lvl & ~prev_reg.clk_lvl;
   assign sel_rise = sync_reg.sel_n_lvl & ~prev_reg.sel_n_lvl;

   // ************************************************************
   // Shift and code registers
   // ************************************************************
   sdl_code_t shift_reg;
   sdl_code_t shift_next;
   sdl_code_t code_reg;
   sdl_code_t code_next;
   logic loaded_reg;
   logic loaded_next;

   always_comb begin
      shift_next = shift_reg;
      code_next = code_reg;
      loaded_next = 1'b0;
      // Data sampled with the clock edge; both share the same delay
      // Oldest bit falls off the top, newest enters at bit 0
      if (clk_rise && !sync_reg.sel_n_lvl) begin
         shift_next = {shift_reg[`SDL_CODE_MSB-1:`SDL_CODE_LSB],
                       sync_reg.data_lvl};
      end
      // A clock rise in the load cycle does not shift: select is already high
      if (sel_rise) begin
         code_next = shift_reg;
         loaded_next = 1'b1;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
         shift_reg <= `SDL_CODE_RESET;
         code_reg <= `SDL_CODE_RESET;
         loaded_reg <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         code_reg <= code_next;
         loaded_reg <= loaded_next;
      end
   end

   // ************************************************************
   // Frame bit counter
   // ************************************************************
   // Clock rises of one select-low frame, for coverage; saturates so a
   // very long frame cannot wrap back to a small count
   logic [4:0] rise_cnt_reg;
   logic [4:0] rise_cnt_next;

   always_comb begin
      rise_cnt_next = rise_cnt_reg;
      if (sync_reg.sel_n_lvl) begin
         rise_cnt_next = 5'h00;
      end else if (clk_rise && rise_cnt_reg != `SDL_RISE_CNT_MAX) begin
         rise_cnt_next = rise_cnt_reg + 5'h01;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
         rise_cnt_reg <= 5'h00;
      end else begin
         rise_cnt_reg <= rise_cnt_next;
      end
   end

   // ************************************************************
   // Ladder leg drive
   // ************************************************************
   // Bit high: leg to current output; low: leg to ground
   assign O_LEG_TO_CURRENT_OUTPUT = code_reg;

   // ************************************************************
   // Scale flags and load strobe
   // ************************************************************
   // Decoded from the register, so they settle with the code
   assign O_FULL_SCALE = (code_reg == `SDL_CODE_FULL);
   assign O_ZERO_SCALE = (code_reg == `SDL_CODE_ZERO);
   assign O_CODE_LOADED = loaded_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   // Off while reset is low; the first edge after release is checked
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_NRST);

   a_shift_on_rise: assert property (
      clk_rise && !sync_reg.sel_n_lvl |=>
      shift_reg == {$past(shift_reg[12:0]), $past(sync_reg.data_lvl)})
      else $error("shift did not advance on clock rise");

   a_hold_no_rise: assert property (
      !clk_rise |=> $stable(shift_reg))
      else $error("shifter changed without clock rise");

   a_last_bit_lsb: assert property (
      clk_rise && !sync_reg.sel_n_lvl |=>
      shift_reg[0] == $past(sync_reg.data_lvl))
      else $error("last bit not at bit 0");

   a_excess_drop: assert property (
      clk_rise && !sync_reg.sel_n_lvl |=>
      shift_reg[13:1] == $past(shift_reg[12:0]))
      else $error("excess bits not discarded");

   a_load_on_sel: assert property (
      sel_rise |=> code_reg == $past(shift_reg) ##0 O_CODE_LOADED)
      else $error("select rise did not load code");

   a_code_output: assert property (
      O_LEG_TO_CURRENT_OUTPUT == code_reg)
      else $error("leg drive differs from code");

   a_sel_high_hold: assert property (
      sync_reg.sel_n_lvl && prev_reg.sel_n_lvl |=>
      $stable(code_reg) && $stable(shift_reg))
      else $error("activity while select high");

   a_scale_flags: assert property (
      O_FULL_SCALE == (O_LEG_TO_CURRENT_OUTPUT == 14'h3FFF) &&
      O_ZERO_SCALE == (O_LEG_TO_CURRENT_OUTPUT == 14'h0000))
      else $error("scale flag wrong");

   a_load_only_sel: assert property (
      !sel_rise |=> $stable(code_reg))
      else $error("code changed without select rise");

   // Data pin to bit 0 through two sync flops and the shift register
   a_pin_to_shift: assert property (
      clk_rise && !sync_reg.sel_n_lvl |=>
      shift_reg[0] == $past(I_SERIAL_DATA_IN, 3))
      else $error("shifted bit differs from data pin");

   a_high_no_shift: assert property (
      clk_rise && sync_reg.sel_n_lvl |=> $stable(shift_reg))
      else $error("shifter moved while select high");

   a_loaded_pulse: assert property (
      O_CODE_LOADED |=> !O_CODE_LOADED)
      else $error("load strobe longer than one cycle");

   a_fall_no_load: assert property (
      !sync_reg.sel_n_lvl && prev_reg.sel_n_lvl |=> $stable(code_reg))
      else $error("select fall changed the code");

   // Main scenarios: shift, load, full and zero codes, 16-bit word
   c_shift: cover property (clk_rise && !sync_reg.sel_n_lvl);
   c_load: cover property (sel_rise);
   c_full: cover property (O_CODE_LOADED && O_FULL_SCALE);
   c_zero: cover property (O_CODE_LOADED && O_ZERO_SCALE);
   c_sixteen: cover property (
      sel_rise && rise_cnt_reg == `SDL_HOST_WORD_BITS);

endmodule

// [sim/sdl_host_model.sv]
/* Host model of the three serial wires of the load port.
   Assumes i_clk is the 40 MHz clock; serial clock period is 200 ns. */
`timescale 1ns/1ps
module sdl_host_model (
   input wire logic i_clk,
   output logic o_sclk,
   output logic o_data,
   output logic o_sel_n
);
   initial begin
      o_sclk = 1'b0;
      o_data = 1'b0;
      o_sel_n = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask
   // ****
   // Frame: clock idles low, msb first
   // ****
   task automatic send(input logic [15:0] w, input int n, input logic sel);
      tick(1);
      o_sel_n = sel;
      for (int i = n - 1; i >= 0; i--) begin
         o_data = w[i];
         tick(4);
         o_sclk = 1'b1;
         tick(4);
         o_sclk = 1'b0;
      end
      tick(4);
      o_sel_n = 1'b1;
      // Released line shows the inverse, never a held value
      o_data = ~o_data;
   endtask
endmodule

// [sim/test_serial_dac_load_interface.sv]
/* Self-checking bench of the serial load port.
   Assumes sdl_host_model drives the wires and the design holds no params. */
`timescale 1ns/1ps
`include "sdl_defs.svh"
module test_serial_dac_load_interface;
   import sdl_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   wire logic sclk, sdat, seln;
   sdl_code_t code;
   logic full, zero, loaded;
   int error_cnt = 0;
   int check_count = 0;
   always #12.5 clk = ~clk;
   sdl_host_model u_host (.i_clk(clk), .o_sclk(sclk), .o_data(sdat),
      .o_sel_n(seln));
   sdl_load_port u_dut (.I_CLOCK(clk), .I_NRST(nrst), .I_SERIAL_CLK(sclk),
      .I_SERIAL_DATA_IN(sdat), .I_SELECT_N(seln),
      .O_LEG_TO_CURRENT_OUTPUT(code), .O_FULL_SCALE(full),
      .O_ZERO_SCALE(zero), .O_CODE_LOADED(loaded));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ****
   // One frame, then code, flags and one-cycle pulse
   // ****
   task automatic load(input logic [15:0] w, input int n, input sdl_code_t e);
      int i;
      i = 0;
      u_host.send(w, n, 1'b0);
      while (loaded !== 1'b1 && i < 10) begin
         @(posedge clk);
         #2;
         i++;
      end
      if (i == 10) begin
         error_cnt++;
         give_verdict();
      end
      check({2'h0, code}, {2'h0, e});
      check({15'h0, full}, {15'h0, e == `SDL_CODE_FULL});
      check({15'h0, zero}, {15'h0, e == `SDL_CODE_ZERO});
      @(posedge clk);
      #2;
      check({15'h0, loaded}, 16'h0000);
   endtask
   // ****
   // Reset values, select-high traffic, reset in mid-run
   // ****
   task automatic check_reset;
      check({2'h0, code}, {2'h0, `SDL_CODE_RESET});
      check({15'h0, zero}, 16'h0001);
      check({15'h0, full}, 16'h0000);
      check({15'h0, loaded}, 16'h0000);
   endtask
   task automatic idle_traffic;
      u_host.send(16'h0000, 8, 1'b1);
      repeat (6) @(posedge clk);
      #2;
      check({2'h0, code}, {2'h0, `SDL_CODE_FULL});
      // Empty frame shows whether the shifter moved while select was high
      load(16'h0000, 0, `SDL_CODE_FULL);
   endtask
   task automatic mid_reset;
      nrst = 1'b0;
      repeat (2) @(posedge clk);
      #2;
      nrst = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      check_reset();
      // Empty frame shows that the shifter was cleared as well
      load(16'h0000, 0, `SDL_CODE_RESET);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #2;
      nrst = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      check_reset();
      load(16'h2A5B, 14, 14'h2A5B);
      mid_reset();
      load(16'h0001, 14, 14'h0001);
      load(16'h7FFF, 16, `SDL_CODE_FULL);
      idle_traffic();
      load(16'hC000, 16, `SDL_CODE_ZERO);
      give_verdict();
   end
endmodule
